// ===== pkg/port_reset_regs.svh
`ifndef PORT_RESET_REGS_SVH
`define PORT_RESET_REGS_SVH

// identity values
`define CLASS_CODE_BRIDGE 24'h06_0400
`define CLASS_CODE_OTHER 24'h06_8000
`define PORT_TYPE_ENDPOINT 4'h0
`define PORT_TYPE_UPSTREAM 4'h5
`define PORT_TYPE_DOWNSTREAM 4'h6
`define HEADER_TYPE_0 1'b0
`define HEADER_TYPE_1 1'b1

// control register offsets and bit positions
`define DEBUG_CTRL_OFFSET 12'h1_DC
`define UP_PROP_DISABLE_BIT 20
`define INTERNAL_ACCESS_BIT 28
`define LINK_ACCESS_BIT 29
`define BRIDGE_CTRL_OFFSET 12'h0_3C
`define SEC_BUS_RESET_BIT 22
`define CAP_OFFSET 12'h0_68
`define PORT_TYPE_LSB 20
`define PORT_TYPE_MSB 23

// local reset pulse timing
`define CLK_PERIOD_PS 25000
`define LOCAL_RESET_NS 1000
`define LOCAL_RESET_CYCLES \
  ((`LOCAL_RESET_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define LOCAL_CNT_W 6

`endif

// ===== pkg/port_reset_pkg.sv
package port_reset_pkg;

  typedef enum logic [1:0] {
    ISO_IDLE = 2'b01,
    ISO_PULSE = 2'b10
  } pulse_state_t;

  typedef enum logic [1:0] {
    ROLE_UPSTREAM = 2'b00,
    ROLE_DOWNSTREAM = 2'b01,
    ROLE_ISOLATING = 2'b10
  } port_role_t;

endpackage

// ===== rtl/local_reset_pulse.sv
`timescale 1ns/1ps
`include "port_reset_regs.svh"

module local_reset_pulse (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic trigger_in,
  output logic local_subsystem_reset_n_out
);

  port_reset_pkg::pulse_state_t state_reg;
  port_reset_pkg::pulse_state_t state_next;
  logic [`LOCAL_CNT_W-1:0] cnt_reg;
  logic [`LOCAL_CNT_W-1:0] cnt_next;
  logic rst_n_reg;
  logic rst_n_next;

  // ***********************************************
  // pulse timer
  // ***********************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rst_n_next = 1'b1;
    case (state_reg)
      port_reset_pkg::ISO_IDLE: begin
        if (trigger_in) begin
          state_next = port_reset_pkg::ISO_PULSE; // [R8]
          cnt_next = `LOCAL_CNT_W'(`LOCAL_RESET_CYCLES - 1); // [R16]
          rst_n_next = 1'b0;
        end
      end
      port_reset_pkg::ISO_PULSE: begin
        rst_n_next = 1'b0;
        if (trigger_in) begin
          // a fresh trigger restarts the count, so the pulse ends a full period after it
          cnt_next = `LOCAL_CNT_W'(`LOCAL_RESET_CYCLES - 1); // [R16]
        end else if (cnt_reg == '0) begin
          state_next = port_reset_pkg::ISO_IDLE;
          rst_n_next = 1'b1; // [R17]
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = port_reset_pkg::ISO_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg <= port_reset_pkg::ISO_IDLE;
      cnt_reg <= '0;
      rst_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rst_n_reg <= rst_n_next;
    end
  end

  assign local_subsystem_reset_n_out = rst_n_reg;

endmodule

// ===== rtl/port_reset_ctrl.sv
// Contract
// R1 - isolating port reports class code 068000h with a type 0 header
// R2 - pass-through ports report class code 060400h
// R3 - port type field: endpoint for isolating, upstream/downstream otherwise
// R4 - fundamental reset returns all state, both sides, to default
// R5 - adapter mode upstream hot reset resets downstream, fabric, internal side
// R6 - propagation-disable bit masks upstream hot reset and link-down reset
// R7 - link-side hot reset resets only link-side registers
// R8 - link-side hot reset or link down drives local reset low 1 us
// R9 - secondary bus reset resets downstream ports and internal side
// R10 - dual-host mode upstream hot reset or link down resets nothing
// R11 - no hot or secondary bus reset crosses the isolating port
// R12 - remote config requests get retry until local host enables link side
// R13 - internal-side config access only while internal enable is set
// R14 - link-side config access only while link enable is set
// R15 - access enables never block memory or mapped register traffic
// R16 - local reset pulse counted on device clock; retrigger restarts count
// R17 - controls sampled synchronously; reset outputs released synchronously
`timescale 1ns/1ps
`include "port_reset_regs.svh"

module port_reset_ctrl (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic fundamental_reset_n_in,
  input wire logic dual_host_mode_in,
  input wire logic isolating_enable_in,
  input wire logic up_prop_disable_in,
  input wire logic internal_access_en_in,
  input wire logic link_access_en_in,
  input wire logic up_hot_reset_in,
  input wire logic up_link_down_in,
  input wire logic sec_bus_reset_in,
  input wire logic link_hot_reset_in,
  input wire logic link_dl_down_in,
  input wire logic internal_cfg_req_in,
  input wire logic link_cfg_req_in,
  input wire logic mem_req_in,
  output logic downstream_reset_out,
  output logic fabric_reset_out,
  output logic internal_side_reset_out,
  output logic link_side_reset_out,
  output logic local_subsystem_reset_n_out,
  output logic internal_cfg_grant_out,
  output logic link_cfg_grant_out,
  output logic link_cfg_retry_out,
  output logic mem_grant_out,
  output logic [23:0] class_code_out,
  output logic header_type_out,
  output logic [3:0] port_type_out,
  output logic [23:0] link_class_code_out,
  output logic [3:0] link_port_type_out
);

  logic all_reset;
  logic up_event;
  logic iso_trigger;

  logic dual_reg;
  logic dual_next;
  logic prop_dis_reg;
  logic prop_dis_next;
  logic int_en_reg;
  logic int_en_next;
  logic link_en_reg;
  logic link_en_next;
  logic iso_reg;
  logic iso_next;
  logic ds_rst_reg;
  logic ds_rst_next;
  logic fab_rst_reg;
  logic fab_rst_next;
  logic int_rst_reg;
  logic int_rst_next;
  logic link_rst_reg;
  logic link_rst_next;
  logic [23:0] class_reg;
  logic [23:0] class_next;
  logic [3:0] ptype_reg;
  logic [3:0] ptype_next;
  logic hdr_reg;
  logic hdr_next;

  // fundamental reset and the local synchronous reset act alike
  assign all_reset = srst_in | ~fundamental_reset_n_in; // [R4]

  // ***********************************************
  // control sampling
  // ***********************************************
  always_comb begin
    dual_next = dual_host_mode_in; // [R17]
    prop_dis_next = up_prop_disable_in;
    int_en_next = internal_access_en_in;
    link_en_next = link_access_en_in;
    iso_next = isolating_enable_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (all_reset) begin
      dual_reg <= 1'b0; // [R4]
      prop_dis_reg <= 1'b0;
      int_en_reg <= 1'b0;
      link_en_reg <= 1'b0;
      iso_reg <= 1'b0;
    end else begin
      dual_reg <= dual_next;
      prop_dis_reg <= prop_dis_next;
      int_en_reg <= int_en_next;
      link_en_reg <= link_en_next;
      iso_reg <= iso_next;
    end
  end

  // ***********************************************
  // reset propagation
  // ***********************************************
  // upstream events are dropped when masked or in dual-host mode
  assign up_event = (up_hot_reset_in | up_link_down_in) & ~prop_dis_reg // [R6]
                    & ~dual_reg; // [R10]

  always_comb begin
    // fundamental reset holds every domain in reset
    ds_rst_next = all_reset;
    fab_rst_next = all_reset;
    int_rst_next = all_reset;
    link_rst_next = all_reset;
    if (up_event) begin
      ds_rst_next = 1'b1; // [R5]
      fab_rst_next = 1'b1;
      int_rst_next = 1'b1;
    end
    if (sec_bus_reset_in) begin
      ds_rst_next = 1'b1; // [R9]
      int_rst_next = 1'b1;
    end
    // only link-side inputs reach the link-side reset
    if (link_hot_reset_in) begin
      link_rst_next = 1'b1; // [R7] [R11]
    end
  end

  // reset outputs released on a clock edge so internal domains exit cleanly
  always_ff @(posedge ref_clk_in) begin
    ds_rst_reg <= ds_rst_next; // [R17]
    fab_rst_reg <= fab_rst_next;
    int_rst_reg <= int_rst_next;
    link_rst_reg <= link_rst_next;
  end

  assign downstream_reset_out = ds_rst_reg;
  assign fabric_reset_out = fab_rst_reg;
  assign internal_side_reset_out = int_rst_reg;
  assign link_side_reset_out = link_rst_reg;

  // ***********************************************
  // local subsystem reset pulse
  // ***********************************************
  assign iso_trigger = iso_reg & (link_hot_reset_in | link_dl_down_in); // [R8]

  local_reset_pulse u_pulse (
    .ref_clk_in(ref_clk_in),
    .srst_in(all_reset),
    .trigger_in(iso_trigger),
    .local_subsystem_reset_n_out(local_subsystem_reset_n_out)
  );

  // ***********************************************
  // configuration access gating
  // ***********************************************
  assign internal_cfg_grant_out = internal_cfg_req_in & int_en_reg; // [R13]
  assign link_cfg_grant_out = link_cfg_req_in & link_en_reg; // [R14]
  assign link_cfg_retry_out = link_cfg_req_in & ~link_en_reg; // [R12]
  // memory and mapped register traffic never sees the enables
  assign mem_grant_out = mem_req_in; // [R15]

  // ***********************************************
  // identity
  // ***********************************************
  always_comb begin
    if (iso_reg) begin
      class_next = `CLASS_CODE_OTHER; // [R1]
      hdr_next = `HEADER_TYPE_0;
      ptype_next = `PORT_TYPE_ENDPOINT; // [R3]
    end else begin
      class_next = `CLASS_CODE_BRIDGE; // [R2]
      hdr_next = `HEADER_TYPE_1;
      ptype_next = `PORT_TYPE_DOWNSTREAM; // [R3]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (all_reset) begin
      class_reg <= `CLASS_CODE_BRIDGE;
      hdr_reg <= `HEADER_TYPE_1;
      ptype_reg <= `PORT_TYPE_DOWNSTREAM;
    end else begin
      class_reg <= class_next;
      hdr_reg <= hdr_next;
      ptype_reg <= ptype_next;
    end
  end

  assign class_code_out = class_reg;
  assign header_type_out = hdr_reg;
  assign port_type_out = ptype_reg;
  // the upstream port always presents a pass-through bridge identity
  assign link_class_code_out = `CLASS_CODE_BRIDGE; // [R2]
  assign link_port_type_out = `PORT_TYPE_UPSTREAM; // [R3]

endmodule

// ===== tb/remote_host_model.sv
`timescale 1ns/1ps
module remote_host_model (
  input wire logic ref_clk_in,
  input wire logic start_in,
  input wire logic grant_in,
  input wire logic retry_in,
  output logic req_out,
  output logic [7:0] retries_out
);
  // a refused request is held and reissued until granted
  always @(posedge ref_clk_in) begin
    if (start_in) begin
      req_out <= 1'b1;
      retries_out <= 8'h00;
    end else if (req_out && grant_in) begin
      req_out <= 1'b0;
    end else if (req_out && retry_in) begin
      retries_out <= retries_out + 8'h01;
    end
  end
endmodule

// ===== tb/port_reset_monitor.sv
`timescale 1ns/1ps
module port_reset_monitor (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic fundamental_reset_n_in,
  input wire logic isolating_enable_in,
  input wire logic link_hot_reset_in,
  input wire logic sec_bus_reset_in,
  input wire logic link_cfg_req_in,
  input wire logic mem_req_in,
  input wire logic downstream_reset_out,
  input wire logic internal_side_reset_out,
  input wire logic link_side_reset_out,
  input wire logic local_subsystem_reset_n_out,
  input wire logic link_cfg_grant_out,
  input wire logic link_cfg_retry_out,
  input wire logic mem_grant_out,
  input wire logic [23:0] class_code_out,
  input wire logic [3:0] port_type_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in || !fundamental_reset_n_in);
  logic [7:0] low_reg;
  logic [7:0] low_next;
  always_comb low_next = local_subsystem_reset_n_out ? 8'h00 : low_reg + 8'h01;
  always_ff @(posedge ref_clk_in) low_reg <= low_next;
  a_pulse_start: assert property (isolating_enable_in ##1
    (isolating_enable_in && link_hot_reset_in) |=> !local_subsystem_reset_n_out)
    else $error("local reset not started");
  a_pulse_len: assert property ($rose(local_subsystem_reset_n_out)
    && $past(fundamental_reset_n_in) && !$past(srst_in) |-> low_reg >= 8'h28)
    else $error("local reset pulse too short");
  a_link_hot: assert property (isolating_enable_in ##1
    (isolating_enable_in && link_hot_reset_in) |=> link_side_reset_out)
    else $error("link side not reset");
  // reset terms keep the edge of reset release out of the antecedent
  a_no_cross: assert property (!link_hot_reset_in && !srst_in
    && fundamental_reset_n_in |=> !link_side_reset_out)
    else $error("reset crossed to link side");
  a_sbr_reset: assert property (sec_bus_reset_in |=>
    downstream_reset_out && internal_side_reset_out)
    else $error("secondary bus reset lost");
  a_retry_gate: assert property (link_cfg_req_in |->
    link_cfg_grant_out != link_cfg_retry_out)
    else $error("link request neither granted nor retried");
  a_grant_need: assert property (link_cfg_grant_out |-> link_cfg_req_in)
    else $error("link grant without request");
  a_mem_free: assert property (mem_grant_out == mem_req_in)
    else $error("memory request gated");
  // identity lags the enable pin by two registers
  a_iso_ident: assert property ((isolating_enable_in && !srst_in
    && fundamental_reset_n_in)[*3] |->
    class_code_out == 24'h06_8000 && port_type_out == 4'h0)
    else $error("isolating identity wrong");
  a_bridge_ident: assert property ((!isolating_enable_in && !srst_in
    && fundamental_reset_n_in)[*3] |-> class_code_out == 24'h06_0400)
    else $error("bridge class code wrong");
endmodule
bind port_reset_ctrl port_reset_monitor mon_u (.*);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in, srst_in, fundamental_reset_n_in, dual_host_mode_in;
  logic isolating_enable_in, up_prop_disable_in, internal_access_en_in;
  logic link_access_en_in, up_hot_reset_in, up_link_down_in, host_start;
  logic sec_bus_reset_in, link_hot_reset_in, link_dl_down_in, mem_req_in;
  logic internal_cfg_req_in, link_cfg_req_in, header_type_out;
  logic downstream_reset_out, fabric_reset_out, internal_side_reset_out;
  logic link_side_reset_out, local_subsystem_reset_n_out, mem_grant_out;
  logic internal_cfg_grant_out, link_cfg_grant_out, link_cfg_retry_out;
  logic [23:0] class_code_out, link_class_code_out;
  logic [3:0] port_type_out, link_port_type_out, got, msk;
  logic [7:0] host_retries;
  int bad_count, checks;
  // dual prop sbr uphot updown linkhot | down fabric internal link
  logic [9:0] rows [8] = '{10'h04E, 10'h02E, 10'h140, 10'h220, 10'h240,
    10'h28A, 10'h011, 10'h311};
  port_reset_ctrl dut_u (.*);
  remote_host_model host_u (.ref_clk_in(ref_clk_in), .start_in(host_start),
    .grant_in(link_cfg_grant_out), .retry_in(link_cfg_retry_out),
    .req_out(link_cfg_req_in), .retries_out(host_retries));
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task check(input bit ok);
    checks++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH t=%0t check %0d failed", $time, checks);
    end
  endtask
  task complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one trigger, optionally a second one gap+1 cycles later
  task pulse(input int gap, input int want);
    int n;
    n = 0;
    link_dl_down_in <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(posedge ref_clk_in);
      link_dl_down_in <= (k == gap && gap > 0);
      #1 n += (local_subsystem_reset_n_out === 1'b0);
    end
    check(n == want);
  endtask
  // ************
  // main sequence
  // ************
  initial begin
    {srst_in, host_start, fundamental_reset_n_in, isolating_enable_in} = 4'hF;
    {dual_host_mode_in, up_prop_disable_in, internal_access_en_in} = 3'h0;
    {link_access_en_in, up_hot_reset_in, up_link_down_in} = 3'h0;
    {sec_bus_reset_in, link_hot_reset_in, link_dl_down_in} = 3'h0;
    {internal_cfg_req_in, mem_req_in} = 2'h0;
    repeat (10) @(posedge ref_clk_in);
    {srst_in, host_start} <= 2'h0;
    for (int i = 0; i < 8; i++) begin
      {dual_host_mode_in, up_prop_disable_in} <= rows[i][9:8];
      repeat (2) @(posedge ref_clk_in);
      {sec_bus_reset_in, up_hot_reset_in, up_link_down_in,
        link_hot_reset_in} <= rows[i][7:4];
      @(posedge ref_clk_in);
      {sec_bus_reset_in, up_hot_reset_in, up_link_down_in,
        link_hot_reset_in} <= 4'h0;
      // fabric left open on secondary bus reset rows
      msk = {1'b0, rows[i][7], 2'h0};
      #1 got = msk | {downstream_reset_out, fabric_reset_out,
        internal_side_reset_out, link_side_reset_out};
      check(got === (rows[i][3:0] | msk));
      repeat (2) @(posedge ref_clk_in);
    end
    check(link_cfg_req_in === 1'b1 && host_retries > 8'h00);
    link_access_en_in <= 1'b1;
    for (int k = 0; k < 10 && link_cfg_req_in !== 1'b0; k++)
      @(posedge ref_clk_in);
    // an exhausted wait counts here and the run goes on to the report
    check(link_cfg_req_in === 1'b0);
    {internal_cfg_req_in, mem_req_in} <= 2'h3;
    @(posedge ref_clk_in);
    #1 check({internal_cfg_grant_out, mem_grant_out} === 2'h1);
    @(posedge ref_clk_in);
    internal_access_en_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 check({internal_cfg_grant_out, mem_grant_out} === 2'h3);
    check({class_code_out, header_type_out, port_type_out} ===
      {24'h06_8000, 1'b0, 4'h0});
    @(posedge ref_clk_in);
    isolating_enable_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 check({class_code_out, header_type_out, port_type_out,
      link_class_code_out, link_port_type_out} ===
      {24'h06_0400, 1'b1, 4'h6, 24'h06_0400, 4'h5});
    @(posedge ref_clk_in);
    isolating_enable_in <= 1'b1;
    repeat (50) @(posedge ref_clk_in);
    pulse(0, 40);
    pulse(20, 61);
    {fundamental_reset_n_in, link_hot_reset_in} <= 2'h1;
    @(posedge ref_clk_in);
    #1 check({class_code_out, local_subsystem_reset_n_out, link_side_reset_out,
      internal_cfg_grant_out} === {24'h06_0400, 3'h6});
    @(posedge ref_clk_in);
    {fundamental_reset_n_in, link_hot_reset_in} <= 2'h2;
    repeat (2) @(posedge ref_clk_in);
    complete_run();
  end
endmodule
